// >>> tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata;
    logic [vpil_pkg::NSRC-1:0] src_evt;
    logic                      ext_reset_n, core_take, core_rd, core_data_valid;
    logic [15:0]               core_addr, vec_addr, handler;
    logic [7:0]                core_data, take_cnt;
    logic                      irq_req, vec_valid, irq, mask_clr;
    logic [4:0]                vec_num;
    int                        fails, check_count, cyc, nt;
    logic [31:0]               rv;
    logic                      er;
    localparam int VX [33] = '{0, 0, 0, 0, 0, 1, 3, 5, 6, 11, 12, 13, 14, 15, 15, 15, 16,
        16, 16, 16, 17, 17, 17, 17, 18, 18, 20, 21, 23, 24, 25, 26, 30};
    vpil_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_evt(src_evt), .ext_reset_n(ext_reset_n),
        .core_take(core_take), .core_rd(core_rd), .core_addr(core_addr),
        .core_data(core_data), .core_data_valid(core_data_valid), .irq_req(irq_req),
        .vec_num(vec_num), .vec_addr(vec_addr), .vec_valid(vec_valid), .irq(irq));
    vpil_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .vec_addr(vec_addr), .core_data(core_data), .mask_clr(mask_clr),
        .core_take(core_take), .core_rd(core_rd), .core_addr(core_addr),
        .handler_q(handler), .take_cnt_q(take_cnt));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] hnd(input int v);
        return {3'b101, v[4:0], 3'b010, ~v[4:0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) fails++;
        rv = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ev(input logic [32:0] m);
        @(posedge pclk);
        src_evt <= m;
        @(posedge pclk);
        src_evt <= '0;
        repeat (3) @(negedge pclk);
    endtask
    task automatic clr(input int s);
        if (s < 32) apb(1'b1, vpil_pkg::OFF_FLAG0, 32'h0000_0001 << s);
        else apb(1'b1, vpil_pkg::OFF_FLAG1, 32'h0000_0001);
    endtask
    task automatic rti();
        @(posedge pclk);
        mask_clr <= 1'b1;
        @(posedge pclk);
        mask_clr <= 1'b0;
    endtask
    task automatic wait_take(input int v);
        int n;
        n = 0;
        nt++;
        while (take_cnt !== nt[7:0] && n < 200) begin
            @(negedge pclk);
            n++;
        end
        if (n == 200) fails++;
        chk("core_data_valid", 1, core_data_valid);
        chk("vec_num", v, vec_num);
        chk("vec_addr", 16'hfffe - 16'(2 * v), vec_addr);
        chk("vec_valid", 1, vec_valid);
        chk("handler", hnd(v), handler);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk("vec_addr", 16'hfffe, vec_addr);
        chk("irq_req", 0, irq_req);
        chk("vec_valid", 0, vec_valid);
        chk("core_data_valid", 0, core_data_valid);
        apb(1'b0, vpil_pkg::OFF_EN0, 0);
        chk("en0", 0, rv);
        $display("test reset done");
    endtask
    task automatic t_gate();
        ev(33'h0_0000_0080);
        apb(1'b0, vpil_pkg::OFF_FLAG0, 0);
        chk("flag0", 32'h0000_0080, rv);
        chk("irq_req", 0, irq_req);
        apb(1'b1, vpil_pkg::OFF_EN0, 32'h0000_0080);
        wait_take(5);
        apb(1'b0, vpil_pkg::OFF_ACT, 0);
        chk("act", 32'h0000_0105, rv);
        repeat (10) @(negedge pclk);
        chk("irq_req", 1, irq_req);
        apb(1'b1, vpil_pkg::OFF_EN0, 0);
        repeat (3) @(negedge pclk);
        chk("irq_req", 0, irq_req);
        clr(7);
        rti();
        apb(1'b1, vpil_pkg::OFF_EN0, 32'h0000_2000);
        ev(33'h0_0000_4000);
        wait_take(15);
        clr(14);
        rti();
        $display("test gate done");
    endtask
    task automatic t_map();
        apb(1'b1, vpil_pkg::OFF_EN0, 32'hffff_ffff);
        apb(1'b1, vpil_pkg::OFF_EN1, 32'h0000_0001);
        for (int s = 0; s < 33; s++) begin
            ev(33'h0_0000_0001 << s);
            wait_take(VX[s]);
            clr(s);
            rti();
        end
        $display("test map done");
    endtask
    task automatic t_prio();
        ev(33'h1_0001_0080);
        wait_take(5);
        clr(7);
        rti();
        wait_take(16);
        clr(16);
        rti();
        wait_take(30);
        clr(32);
        rti();
        $display("test prio done");
    endtask
    task automatic t_tied();
        logic [31:0] e;
        e = 0;
        for (int s = 0; s < 33; s++) e[VX[s]] = 1'b1;
        ev('1);
        apb(1'b0, vpil_pkg::OFF_PEND, 0);
        chk("pend", e, rv);
        wait_take(0);
        apb(1'b1, vpil_pkg::OFF_FLAG0, 32'hffff_ffff);
        clr(32);
        rti();
        $display("test tied done");
    endtask
    task automatic t_pin();
        @(posedge pclk);
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge pclk);
        ext_reset_n <= 1'b1;
        wait_take(0);
        repeat (3) @(posedge pclk);
        clr(2);
        rti();
        repeat (3) @(negedge pclk);
        chk("irq_req", 0, irq_req);
        $display("test pin done");
    endtask
    task automatic t_irq();
        apb(1'b1, vpil_pkg::OFF_IMASK, 32'h0000_0001);
        apb(1'b0, vpil_pkg::OFF_ISTAT, 0);
        repeat (3) @(negedge pclk);
        chk("irq", 0, irq);
        ev(33'h0_0000_0040);
        chk("irq", 1, irq);
        wait_take(3);
        apb(1'b0, vpil_pkg::OFF_ISTAT, 0);
        chk("istat", 32'h0000_0003, rv);
        repeat (3) @(negedge pclk);
        chk("irq", 0, irq);
        clr(6);
        rti();
        apb(1'b1, vpil_pkg::OFF_IMASK, 0);
        apb(1'b0, 8'h20, 0);
        chk("pslverr", 1, er);
        $display("test irq done");
    endtask
    // ****************************************
    // run control
    // ****************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        fails = 0;
        check_count = 0;
        cyc = 0;
        nt = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        src_evt = '0;
        ext_reset_n = 1'b1;
        mask_clr = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        for (int v = 0; v < 32; v++) apb(1'b1, 8'h80 + 8'(4 * v), {16'h0000, hnd(v)});
        rti();
        t_gate();
        t_map();
        t_prio();
        t_tied();
        t_pin();
        t_irq();
        stop_test();
    end
endmodule

// >>> vpil_core_model.sv
module vpil_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        irq_req,
    input  wire logic [15:0] vec_addr,
    input  wire logic [7:0]  core_data,
    input  wire logic        mask_clr,
    output logic             core_take,
    output logic             core_rd,
    output logic      [15:0] core_addr,
    output logic      [15:0] handler_q,
    output logic      [7:0]  take_cnt_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // core sequence
    // ****************************************
    logic [3:0] st_q;
    logic       mask_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= 4'h0;
            mask_q     <= 1'b1;
            core_take  <= 1'b0;
            core_rd    <= 1'b0;
            core_addr  <= 16'h0000;
            handler_q  <= 16'h0000;
            take_cnt_q <= 8'h00;
        end else begin
            core_take <= 1'b0;
            case (st_q)
                4'h0: if (irq_req && !mask_q) st_q <= 4'h1;
                4'h5: begin
                    mask_q    <= 1'b1;
                    core_take <= 1'b1;
                    st_q      <= 4'h6;
                end
                4'h7: begin
                    core_rd   <= 1'b1;
                    core_addr <= vec_addr;
                    st_q      <= 4'h8;
                end
                4'h8: begin
                    core_addr <= core_addr + 16'h0001;
                    st_q      <= 4'h9;
                end
                4'h9: begin
                    core_rd         <= 1'b0;
                    core_addr       <= ~core_addr;
                    handler_q[15:8] <= core_data;
                    st_q            <= 4'ha;
                end
                4'ha: begin
                    handler_q[7:0] <= core_data;
                    take_cnt_q     <= take_cnt_q + 8'h01;
                    st_q           <= 4'h0;
                end
                // five pushes, program counter low byte first
                default: st_q <= st_q + 4'h1;
            endcase
            if (mask_clr) mask_q <= 1'b0;
        end
    end
endmodule

// >>> vpil_pkg.sv
// Summary of operation
// RULE1: vectors 0..31 prioritised; lower number always wins, vector 0 highest.
// RULE2: each vector is two bytes; high byte at lower address, low byte next.
// RULE3: a source event sets its flag whatever its local enable says.
// RULE4: a request goes to the core only while flag and enable are both set.
// RULE5: the core accepts only while its global mask is clear, after the instruction.
// RULE6: the core stacks five registers in order, then sets its global mask.
// RULE7: after stacking, the winning vector address pending at that moment is presented.
// RULE8: vector 0 reset: watchdog, low-supply reset, pin, illegal opcode, illegal address.
// RULE9: vector 1 is the software trap; it has no local enable.
// RULE10: vector 3 is the low-supply warning flag with its own enable.
// RULE11: first timer: channel 0 vector 5, channel 1 vector 6, overflow 11.
// RULE12: second timer: channel 0 vector 12, channel 1 vector 13, overflow 14.
// RULE13: shift port on vector 15; done and mode fault share one enable.
// RULE14: async serial: errors vector 16, receive vector 17, transmit vector 18.
// RULE15: port A pins vector 20, port B pins vector 21, own flag and enable.
// RULE16: converter 23, two-wire 24, periodic wakeup 25, modulo timer 26.
// RULE17: analog comparator on vector 30, the lowest used priority.
// RULE18: unused vectors are tied off and never pending.
// RULE19: a request stays pending until software clears its flag or enable.
package vpil_pkg;
    localparam int NSRC = 33;
    localparam int NVEC = 32;
    localparam int NST  = 2;

    localparam logic [7:0] OFF_FLAG0 = 8'h00;
    localparam logic [7:0] OFF_FLAG1 = 8'h04;
    localparam logic [7:0] OFF_EN0   = 8'h08;
    localparam logic [7:0] OFF_EN1   = 8'h0c;
    localparam logic [7:0] OFF_PEND  = 8'h10;
    localparam logic [7:0] OFF_ACT   = 8'h14;
    localparam logic [7:0] OFF_ISTAT = 8'h18;
    localparam logic [7:0] OFF_IMASK = 8'h1c;

    localparam logic [15:0] VEC_TOP  = 16'hfffe;
    localparam logic [9:0]  VEC_PAGE = 10'h3ff;
    localparam logic [15:0] RST_VTAB = 16'h0000;

    localparam int SRC_PIN      = 2;
    localparam int SRC_SPI_DONE = 13;
    localparam int SRC_SPI_ERR  = 14;
    localparam int ACT_REQ      = 8;
    localparam int ST_REQ       = 0;
    localparam int ST_TAKEN     = 1;

    // pin reset, illegal opcode, illegal address and software trap
    localparam logic [NSRC-1:0] SRC_NOEN = 33'h0_0000_003c;
    localparam logic [NVEC-1:0] VEC_TIED = 32'hb848_0794;

    // vector number of each source flag
    localparam logic [4:0] SRC_VEC [NSRC] = '{
        // RULE8: reset group
        5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        // RULE9: software trap
        5'h01,
        // RULE10: supply warning
        5'h03,
        // RULE11: first timer
        5'h05, 5'h06, 5'h0b,
        // RULE12: second timer
        5'h0c, 5'h0d, 5'h0e,
        // RULE13: shift port
        5'h0f, 5'h0f, 5'h0f,
        // RULE14: async serial
        5'h10, 5'h10, 5'h10, 5'h10,
        5'h11, 5'h11, 5'h11, 5'h11,
        5'h12, 5'h12,
        // RULE15: port pins
        5'h14, 5'h15,
        // RULE16: converter, two-wire, wakeup, modulo
        5'h17, 5'h18, 5'h19, 5'h1a,
        // RULE17: comparator
        5'h1e
    };
endpackage

// >>> vpil_top.sv
// The address map and the APB slave port were left to the implementer.
module vpil_top (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [vpil_pkg::NSRC-1:0] src_evt,
    input  wire logic                      ext_reset_n,
    input  wire logic                      core_take,
    input  wire logic                      core_rd,
    input  wire logic [15:0]               core_addr,
    output logic      [7:0]                core_data,
    output logic                           core_data_valid,
    output logic                           irq_req,
    output logic      [4:0]                vec_num,
    output logic      [15:0]               vec_addr,
    output logic                           vec_valid,
    output logic                           irq
);
    // ***********************************
    // declarations
    // ***********************************
    localparam int NS = vpil_pkg::NSRC;
    localparam int NV = vpil_pkg::NVEC;
    localparam int NST_W = vpil_pkg::NST - 1;

    logic [NS-1:0]  flag_q;
    logic [NS-1:0]  flag_d;
    logic [NS-1:0]  en_q;
    logic [NS-1:0]  en_eff;
    logic [NS-1:0]  act;
    logic [NS-1:0]  set_w;
    logic [NS-1:0]  clr_w;
    logic [NS-1:0]  hit_w [NV];
    logic [NV-1:0]  pend_w;
    logic [4:0]     win_w;
    logic           any_w;
    logic           pin_s1_q;
    logic           pin_s2_q;
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic [31:0]    rd_mux;
    logic           rd_hit;
    logic           setup;
    logic           wr_fire;
    logic           rd_fire;
    logic [15:0]    vt_rdata;
    logic [NST_W:0] istat_q;
    logic [NST_W:0] istat_d;
    logic [NST_W:0] imask_q;
    logic [NST_W:0] ev_w;
    logic           irq_req_q;
    logic [4:0]     vec_num_q;
    logic [15:0]    vec_addr_q;
    logic           vec_valid_q;
    logic           irq_q;


    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign irq_req   = irq_req_q;
    assign vec_num   = vec_num_q;
    assign vec_addr  = vec_addr_q;
    assign vec_valid = vec_valid_q;
    assign irq       = irq_q;

    // ***********************************
    // reset pin synchroniser
    // ***********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= ext_reset_n;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ***********************************
    // apb decode
    // ***********************************
    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign rd_fire = psel && penable && pready_q && !pwrite;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr[7]) begin
            rd_mux = {16'h0000, vt_rdata};
        end else begin
            case (paddr)
                vpil_pkg::OFF_FLAG0: begin
                    rd_mux = flag_q[31:0];
                end
                vpil_pkg::OFF_FLAG1: begin
                    rd_mux = {31'h0000_0000, flag_q[NS-1]};
                end
                vpil_pkg::OFF_EN0: begin
                    rd_mux = en_q[31:0];
                end
                vpil_pkg::OFF_EN1: begin
                    rd_mux = {31'h0000_0000, en_q[NS-1]};
                end
                vpil_pkg::OFF_PEND: begin
                    rd_mux = pend_w;
                end
                vpil_pkg::OFF_ACT: begin
                    rd_mux[vpil_pkg::ACT_REQ] = irq_req_q;
                    rd_mux[4:0] = vec_num_q;
                end
                vpil_pkg::OFF_ISTAT: begin
                    rd_mux[NST_W:0] = istat_q;
                end
                vpil_pkg::OFF_IMASK: begin
                    rd_mux[NST_W:0] = imask_q;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    // zero wait states: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (setup) begin
            pready_q  <= 1'b1;
            pslverr_q <= !rd_hit;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ***********************************
    // source flags and enables
    // ***********************************
    always_comb begin
        set_w = src_evt;
        set_w[vpil_pkg::SRC_PIN] = src_evt[vpil_pkg::SRC_PIN] || !pin_s2_q;
        clr_w = '0;
        if (wr_fire && paddr == vpil_pkg::OFF_FLAG0) begin
            clr_w[31:0] = pwdata;
        end
        if (wr_fire && paddr == vpil_pkg::OFF_FLAG1) begin
            clr_w[NS-1] = pwdata[0];
        end
        // RULE3: set regardless of enable, set wins over clear
        flag_d = set_w | (flag_q & ~clr_w);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= '0;
        end else if (wr_fire && paddr == vpil_pkg::OFF_EN0) begin
            en_q[31:0] <= pwdata;
        end else if (wr_fire && paddr == vpil_pkg::OFF_EN1) begin
            en_q[NS-1] <= pwdata[0];
        end
    end

    always_comb begin
        // RULE8: sources without enable
        en_eff = en_q | vpil_pkg::SRC_NOEN;
        // RULE13: mode fault uses done enable
        en_eff[vpil_pkg::SRC_SPI_ERR] = en_q[vpil_pkg::SRC_SPI_DONE];
        // RULE4: flag and enable both set
        act = flag_q & en_eff;
    end

    // ***********************************
    // vector pending and priority
    // ***********************************
    for (genvar v = 0; v < NV; v++) begin : g_vec
        for (genvar s = 0; s < NS; s++) begin : g_src
            assign hit_w[v][s] = act[s] && vpil_pkg::SRC_VEC[s] == 5'(v);
        end
        // RULE18: unused vectors masked off
        assign pend_w[v] = |hit_w[v] && !vpil_pkg::VEC_TIED[v];
    end

    // RULE1: lowest number wins
    always_comb begin
        win_w = 5'h00;
        for (int i = NV - 1; i >= 0; i--) begin
            if (pend_w[i]) begin
                win_w = 5'(i);
            end
        end
    end
    assign any_w = |pend_w;

    // ***********************************
    // core side
    // ***********************************
    // RULE19: request level follows flag and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req_q <= 1'b0;
        end else begin
            irq_req_q <= any_w;
        end
    end

    // RULE7: latch winner when the core has stacked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_num_q   <= 5'h00;
            vec_addr_q  <= vpil_pkg::VEC_TOP;
            vec_valid_q <= 1'b0;
        end else if (core_take) begin
            vec_num_q   <= win_w;
            vec_addr_q  <= vpil_pkg::VEC_TOP - {10'h000, win_w, 1'b0};
            vec_valid_q <= any_w;
        end
    end

    vpil_vtab #(
        .N (NV)
    ) u_vtab (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (wr_fire && paddr[7]),
        .wr_idx      (paddr[6:2]),
        .wr_data     (pwdata[15:0]),
        .rd_idx      (paddr[6:2]),
        .rd_data     (vt_rdata),
        .core_rd     (core_rd),
        .core_addr   (core_addr),
        .core_data_q (core_data),
        .core_hit_q  (core_data_valid)
    );

    // ***********************************
    // block interrupt
    // ***********************************
    always_comb begin
        ev_w = '0;
        ev_w[vpil_pkg::ST_REQ]   = any_w && !irq_req_q;
        ev_w[vpil_pkg::ST_TAKEN] = core_take && any_w;
        istat_d = istat_q;
        if (rd_fire && paddr == vpil_pkg::OFF_ISTAT) begin
            istat_d = istat_q & ~prdata_q[NST_W:0];
        end
        istat_d = istat_d | ev_w;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= istat_d;
            irq_q   <= |(istat_d & (wr_fire && paddr == vpil_pkg::OFF_IMASK ?
                                    pwdata[NST_W:0] : imask_q));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= '0;
        end else if (wr_fire && paddr == vpil_pkg::OFF_IMASK) begin
            imask_q <= pwdata[NST_W:0];
        end
    end

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_prio;
        core_take && any_w |=>
            ($past(pend_w) & (32'h0000_0001 << vec_num_q)) != 32'h0000_0000 &&
            ($past(pend_w) & ((32'h0000_0001 << vec_num_q) - 32'h0000_0001)) == 32'h0000_0000;
    endproperty
    a_prio: assert property (p_prio) // RULE1
        else $error("winning vector is not the lowest pending");

    property p_vaddr;
        core_take |=> vec_addr_q == vpil_pkg::VEC_TOP - {10'h000, vec_num_q, 1'b0};
    endproperty
    a_vaddr: assert property (p_vaddr) // RULE7
        else $error("vector address does not match vector number");

    property p_set;
        |src_evt |=> ($past(src_evt) & ~flag_q) == '0;
    endproperty
    a_set: assert property (p_set) // RULE3
        else $error("source event did not set its flag");

    property p_req;
        ##1 irq_req_q == $past(|(flag_q & en_eff));
    endproperty
    a_req: assert property (p_req) // RULE4
        else $error("request does not follow flag and enable");

    property p_tied;
        (pend_w & vpil_pkg::VEC_TIED) == 32'h0000_0000;
    endproperty
    a_tied: assert property (p_tied) // RULE18
        else $error("unused vector shows pending");

    property p_noen;
        flag_q[vpil_pkg::SRC_PIN] |-> pend_w[0];
    endproperty
    a_noen: assert property (p_noen) // RULE8
        else $error("pin reset flag not pending on vector 0");

    property p_pin;
        $fell(ext_reset_n) ##1 !ext_reset_n |-> ##[1:3] flag_q[vpil_pkg::SRC_PIN];
    endproperty
    a_pin: assert property (p_pin) // RULE8
        else $error("reset pin did not set its flag");

    property p_trap;
        flag_q[5] |-> pend_w[1];
    endproperty
    a_trap: assert property (p_trap) // RULE9
        else $error("software trap not pending on vector 1");

    property p_spi;
        flag_q[vpil_pkg::SRC_SPI_ERR] && en_q[vpil_pkg::SRC_SPI_DONE] |-> pend_w[15];
    endproperty
    a_spi: assert property (p_spi) // RULE13
        else $error("mode fault not gated by shared enable");

    property p_hold;
        irq_req_q && any_w && !wr_fire |=> any_w ##1 (any_w || $past(wr_fire));
    endproperty
    a_hold: assert property (p_hold) // RULE19
        else $error("request withdrawn without software clear");

    property p_irq;
        (istat_q & imask_q) != '0 |-> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("block interrupt low with unmasked status");

    c_take: cover property (core_take && any_w ##1 vec_valid_q);
    c_two: cover property (pend_w[0] && pend_w[30]);
    c_clr: cover property (wr_fire && paddr == vpil_pkg::OFF_FLAG0 && |src_evt);
    c_irq: cover property ($rose(irq_q));
endmodule

// >>> vpil_vtab.sv
module vpil_vtab #(
    parameter int N = vpil_pkg::NVEC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_idx,
    input  wire logic [15:0] wr_data,
    input  wire logic [4:0]  rd_idx,
    output logic      [15:0] rd_data,
    input  wire logic        core_rd,
    input  wire logic [15:0] core_addr,
    output logic      [7:0]  core_data_q,
    output logic             core_hit_q
);
    logic [15:0] tab_q [N];
    logic [4:0]  cidx;
    logic        chit;

    assign rd_data = tab_q[rd_idx];
    assign cidx    = ~core_addr[5:1];
    assign chit    = core_addr[15:6] == vpil_pkg::VEC_PAGE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                tab_q[i] <= vpil_pkg::RST_VTAB;
            end
        end else if (wr_en) begin
            tab_q[wr_idx] <= wr_data;
        end
    end

    // RULE2: high byte at even address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_data_q <= 8'h00;
            core_hit_q  <= 1'b0;
        end else if (core_rd) begin
            core_hit_q  <= chit;
            core_data_q <= core_addr[0] ? tab_q[cidx][7:0] : tab_q[cidx][15:8];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hi_byte;
        core_rd && core_addr == vpil_pkg::VEC_TOP && !wr_en |=>
            core_data_q == $past(tab_q[0][15:8]) && core_hit_q;
    endproperty
    a_hi_byte: assert property (p_hi_byte) // RULE2
        else $error("vector 0 high byte not at lower address");
endmodule
